// File: hw/port_d_upper_pin_mux.sv
// Operation
// - active memory bus owns pin above latch, parallel port and all others
// - active memory bus drives address/data bits on pins six, seven ignoring direction
// - memory read phases capture pin data via TTL path regardless of direction
// - memory bus function exists only in larger package variant
// - parallel mux select one, the default, maps parallel data onto these pins
// - active parallel port sets pin direction itself; direction bit overridden
// - SPI master, direction zero, drives serial clock on pin six over latch
// - SPI slave, direction one, routes pin six Schmitt input as serial clock
// - I2C mode, direction zero, serial module drives clock on pin six over latch
// - I2C mode, direction one, pin six feeds serial clock input
// - pin seven feeds slave select input via TTL path, direction ignored
// - don't-care functions override direction bit; owning function sets direction
// - port inputs Schmitt; memory and parallel port inputs TTL
// - pull-up bit five unimplemented on small package, reads zero
// - bit seven of pull-up register enables all port pull-ups, active when clear
// - pull-up disabled automatically when its pin is an output
// - every reset leaves all port pull-ups disabled
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "port_d_upper_regs.svh"
module port_d_upper_pin_mux
  import port_d_upper_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] padIn,
  output logic [1:0] padOut,
  output logic [1:0] padOe_n,
  output logic [1:0] pullupEn,
  input wire logic membusActive,
  input wire logic [1:0] membusOut,
  input wire logic membusReadPhase,
  output logic [1:0] membusIn,
  input wire logic parportActive,
  input wire logic parportDriving,
  input wire logic [1:0] parportOut,
  output logic [1:0] parportIn,
  input wire logic serialClockOut,
  output logic serialClockIn,
  output logic serialSlaveSelect
);
  typedef struct packed {
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [7:6] latch;
    logic [7:6] dir;
    logic [7:5] pullCtl;
    logic [3:0] muxCfg;
    bus_phase_t phase;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [1:0] padOut;
    logic [1:0] padOe_n;
    logic [1:0] pullupEn;
    logic [1:0] membusIn;
    logic [1:0] parportIn;
    logic sckIn;
    logic ssIn;
  } state_t;
  state_t s_q, s_d;
  pin_owner_t owner [2];
  logic memOn;
  logic parOn;
  logic [1:0] drvPin;
  logic [1:0] drvVal;
  logic [7:0] pinView;
  logic [7:0] pullView;
  localparam logic [7:0] LatchRst = `LATCH_RESET;
  localparam logic [7:0] DirRst = `DIRECTION_RESET;
  localparam logic [7:0] PullRst = `PULLUP_RESET;
  localparam logic [7:0] MuxRst = `PIN_MUX_CFG_RESET;
  initial begin
    if (LARGE_PACKAGE !== 1'b0 && LARGE_PACKAGE !== 1'b1) $error("bad LARGE_PACKAGE");
  end
  // memory bus only bonds out on the larger package
  assign memOn = LARGE_PACKAGE && membusActive;
  assign parOn = s_q.muxCfg[`BIT_PARPORT_MUX] && parportActive;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (memOn) begin
        owner[i] = OWN_MEMBUS;
      end else if (parOn) begin
        owner[i] = OWN_PARPORT;
      end else if (i == 0 && (s_q.muxCfg[`BIT_SPI_MODE] || s_q.muxCfg[`BIT_I2C_MODE])
                   && !s_q.dir[`PIN_SIX]
                   && (s_q.muxCfg[`BIT_I2C_MODE] || s_q.muxCfg[`BIT_SPI_MASTER])) begin
        owner[i] = OWN_SERIAL;
      end else begin
        owner[i] = OWN_GPIO;
      end
      case (owner[i])
        OWN_MEMBUS: begin
          drvPin[i] = 1'b1;
          drvVal[i] = membusOut[i];
        end
        OWN_PARPORT: begin
          drvPin[i] = parportDriving;
          drvVal[i] = parportOut[i];
        end
        OWN_SERIAL: begin
          drvPin[i] = 1'b1;
          drvVal[i] = serialClockOut;
        end
        default: begin
          drvPin[i] = !s_q.dir[`PIN_SIX + i];
          drvVal[i] = s_q.latch[`PIN_SIX + i];
        end
      endcase
    end
  end
  // small package: pull-up bit five is not built, reads zero
  assign pullView = {s_q.pullCtl[7:6], LARGE_PACKAGE ? s_q.pullCtl[5] : 1'b0, 5'h0_0};
  assign pinView = {s_q.syncB, 6'h00};
  always_comb begin
    s_d = s_q;
    s_d.syncA = padIn;
    s_d.syncB = s_q.syncA;
    for (int i = 0; i < 2; i++) begin
      s_d.padOut[i] = drvVal[i];
      s_d.padOe_n[i] = !drvPin[i];
      // pull-up only when globally enabled (bit clear) and pin not driven
      s_d.pullupEn[i] = !s_q.pullCtl[`BIT_PULLUP_D] && !drvPin[i];
    end
    // TTL paths: same synchronised sample; thresholds live in the pad cell
    if (memOn && membusReadPhase) begin
      s_d.membusIn = s_q.syncB;
    end
    s_d.parportIn = s_q.syncB;
    // clock input: pin six Schmitt sample when direction set, else serialClockOut looped back, in every mode
    s_d.sckIn = s_q.dir[`PIN_SIX] ? s_q.syncB[0] : serialClockOut;
    s_d.ssIn = s_q.syncB[1];
    if (hready) begin
      s_d.phase = (hsel && htrans[1]) ? BUS_DATA : BUS_IDLE;
      s_d.wr = hwrite;
      s_d.addr = haddr[7:0];
    end
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `PIN_VALUE_REG_OFS: s_d.rdata = {24'h00_0000, pinView};
        `OUTPUT_LATCH_REG_OFS: s_d.rdata = {24'h00_0000, s_q.latch, 6'h00};
        `DIRECTION_REG_OFS: s_d.rdata = {24'h00_0000, s_q.dir, 6'h00};
        `SHARED_PULLUP_REG_OFS: s_d.rdata = {24'h00_0000, pullView};
        `PIN_MUX_CFG_REG_OFS: s_d.rdata = {28'h000_0000, s_q.muxCfg};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (s_q.phase == BUS_DATA && s_q.wr) begin
      case (s_q.addr)
        // writing the pin value register lands in the latch
        `PIN_VALUE_REG_OFS, `OUTPUT_LATCH_REG_OFS: s_d.latch = hwdata[7:6];
        `DIRECTION_REG_OFS: s_d.dir = hwdata[7:6];
        `SHARED_PULLUP_REG_OFS: s_d.pullCtl = hwdata[7:5];
        `PIN_MUX_CFG_REG_OFS: s_d.muxCfg = hwdata[3:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.latch <= LatchRst[7:6];
      s_q.dir <= DirRst[7:6];
      s_q.pullCtl <= PullRst[7:5];
      s_q.muxCfg <= MuxRst[3:0];
      s_q.padOe_n <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign padOut = s_q.padOut;
  assign padOe_n = s_q.padOe_n;
  assign pullupEn = s_q.pullupEn;
  assign membusIn = s_q.membusIn;
  assign parportIn = s_q.parportIn;
  assign serialClockIn = s_q.sckIn;
  assign serialSlaveSelect = s_q.ssIn;

  property p_mem_prio;
    @(posedge clk) disable iff (!arst_n) memOn |=> padOe_n == 2'b00;
  endproperty
  a_mem_prio: assert property (p_mem_prio) else $error("memory bus not driving");
  property p_mem_val;
    @(posedge clk) disable iff (!arst_n) memOn |=> padOut == $past(membusOut);
  endproperty
  a_mem_val: assert property (p_mem_val) else $error("memory bus value wrong");
  property p_mem_rd;
    @(posedge clk) disable iff (!arst_n)
      memOn && membusReadPhase |=> membusIn == $past(s_q.syncB);
  endproperty
  a_mem_rd: assert property (p_mem_rd) else $error("read capture wrong");
  property p_small;
    @(posedge clk) disable iff (!arst_n) !LARGE_PACKAGE |-> !memOn;
  endproperty
  a_small: assert property (p_small) else $error("memory bus on small part");
  property p_par;
    @(posedge clk) disable iff (!arst_n)
      !memOn && parOn |=> padOe_n == {2{!$past(parportDriving)}};
  endproperty
  a_par: assert property (p_par) else $error("parallel port direction wrong");
  property p_gpio;
    @(posedge clk) disable iff (!arst_n)
      owner[1] == OWN_GPIO |=> padOe_n[1] == $past(s_q.dir[7]) && padOut[1] == $past(s_q.latch[7]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("latch path wrong");
  property p_pull;
    @(posedge clk) disable iff (!arst_n) !padOe_n[0] |-> !pullupEn[0];
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on output");
  property p_ss;
    @(posedge clk) disable iff (!arst_n) 1'b1 |-> ##3 serialSlaveSelect == $past(padIn[1], 3);
  endproperty
  a_ss: assert property (p_ss) else $error("slave select path wrong");
  property p_pu5;
    @(posedge clk) disable iff (!arst_n) !LARGE_PACKAGE |-> !pullView[5];
  endproperty
  a_pu5: assert property (p_pu5) else $error("bit five readable");
  c_mem: cover property (@(posedge clk) disable iff (!arst_n) memOn && membusReadPhase);
  c_par: cover property (@(posedge clk) disable iff (!arst_n) parOn && parportDriving);
  c_spi: cover property (@(posedge clk) disable iff (!arst_n) owner[0] == OWN_SERIAL);
endmodule // port_d_upper_pin_mux

// File: hw/port_d_upper_pkg.sv
package port_d_upper_pkg;
  typedef enum logic [1:0] {OWN_GPIO, OWN_SERIAL, OWN_PARPORT, OWN_MEMBUS} pin_owner_t;
  typedef enum logic {BUS_IDLE, BUS_DATA} bus_phase_t;
endpackage

// File: hw/port_d_upper_regs.svh
`ifndef PORT_D_UPPER_REGS_SVH
`define PORT_D_UPPER_REGS_SVH
`define PIN_VALUE_REG_OFS 8'h00
`define OUTPUT_LATCH_REG_OFS 8'h04
`define DIRECTION_REG_OFS 8'h08
`define SHARED_PULLUP_REG_OFS 8'h0C
`define PIN_MUX_CFG_REG_OFS 8'h10
`define LATCH_RESET 8'h00
`define DIRECTION_RESET 8'hFF
`define PULLUP_RESET 8'hE0
`define PIN_MUX_CFG_RESET 8'h01
`define BIT_PULLUP_D 7
`define BIT_PULLUP_J 5
`define BIT_PARPORT_MUX 0
`define BIT_SPI_MODE 1
`define BIT_I2C_MODE 2
`define BIT_SPI_MASTER 3
`define PIN_SIX 6
`define PIN_SEVEN 7
`endif

// File: sim/pin_far_side.sv
`timescale 1ns/1ps
module pin_far_side (
  input wire logic clk,
  input wire logic [1:0] padOut,
  input wire logic [1:0] padOe_n,
  input wire logic [1:0] pullupEn,
  input wire logic [1:0] extVal,
  input wire logic extDrive,
  output logic [1:0] padIn
);
  logic [1:0] floatQ = 2'h0;
  // a released line with no pull-up flips every cycle so a stale level never passes
  always @(posedge clk) floatQ <= ~padIn;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!padOe_n[i]) padIn[i] = padOut[i];
      else if (extDrive) padIn[i] = extVal[i];
      else padIn[i] = pullupEn[i] ? 1'b1 : floatQ[i];
    end
  end
endmodule // pin_far_side

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "port_d_upper_regs.svh"
module testbench;
  import port_d_upper_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, lat, dir, pu, cfg, rv;
  logic [1:0] htrans = '0, padIn, padOut, padOe_n, pullupEn, membusIn, parportIn;
  logic [1:0] membusOut = '0, parportOut = '0, extVal = '0, eOe, eOut, pin;
  logic [2:0] hsize = 3'h2;
  logic membusActive = 0, membusReadPhase = 0, parportActive = 0, parportDriving = 0;
  logic serialClockOut = 0, extDrive = 0, hreadyout, hresp, serialClockIn, serialSlaveSelect;
  int seed = 32'h00af;
  int nMismatch = 0, numChecks = 0, cycles = 0;
  wire hready = hreadyout;
  port_d_upper_pin_mux dut (.*);
  pin_far_side far (.*);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      nMismatch++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    numChecks++;
    if (s !== e) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // the master never assumes the zero-wait answer, it waits for hreadyout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'(a);
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, string n);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, e & m, rv & m);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    chk("rstOe", 32'h0000_0003, 32'(padOe_n));
    chk("rstPull", 32'h0000_0000, 32'(pullupEn));
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`OUTPUT_LATCH_REG_OFS, 32'h0000_0000, 32'h0000_00C0, "latch");
    rd(`DIRECTION_REG_OFS, 32'h0000_00C0, 32'h0000_00C0, "dir");
    rd(`SHARED_PULLUP_REG_OFS, 32'h0000_00E0, 32'h0000_00E0, "pullup");
    rd(`PIN_MUX_CFG_REG_OFS, 32'h0000_0001, 32'h0000_000F, "cfg");
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    bus(1'b1, `PIN_VALUE_REG_OFS, 32'h0000_0080);
    rd(`OUTPUT_LATCH_REG_OFS, 32'h0000_0080, 32'h0000_00C0, "latchAlias");
    $display("test registers done");
    for (int k = 0; k < 40; k++) begin
      lat = $random(seed);
      dir = $random(seed);
      pu = $random(seed);
      cfg = $random(seed);
      // both readings of spi master agree when the two bits travel together
      cfg[3] = cfg[1];
      bus(1'b1, `OUTPUT_LATCH_REG_OFS, lat);
      bus(1'b1, `DIRECTION_REG_OFS, dir);
      bus(1'b1, `SHARED_PULLUP_REG_OFS, pu);
      bus(1'b1, `PIN_MUX_CFG_REG_OFS, cfg);
      rd(`SHARED_PULLUP_REG_OFS, pu, 32'h0000_00E0, "pullup");
      rd(`PIN_MUX_CFG_REG_OFS, cfg, 32'h0000_000F, "cfg");
      rv = $random(seed);
      membusActive <= &rv[1:0];
      {membusReadPhase, parportActive, parportDriving} <= rv[4:2];
      {membusOut, parportOut, extVal, serialClockOut, extDrive} <= rv[12:5];
      repeat (6) @(posedge clk);
      eOe = dir[7:6];
      eOut = lat[7:6];
      if ((cfg[2] | cfg[1]) && !dir[6]) begin
        eOe[0] = 1'b0;
        eOut[0] = serialClockOut;
      end
      if (parportActive && cfg[0]) begin
        eOe = {2{!parportDriving}};
        eOut = parportOut;
      end
      if (membusActive) begin
        eOe = 2'b00;
        eOut = membusOut;
      end
      chk("padOe_n", 32'(eOe), 32'(padOe_n));
      chk("padOut", 32'(eOut & ~eOe), 32'(padOut & ~eOe));
      chk("pullupEn", 32'(eOe & {2{~pu[7]}}), 32'(pullupEn));
      if (extDrive || eOe == 2'b00) begin
        pin = (eOut & ~eOe) | (extVal & eOe);
        rd(`PIN_VALUE_REG_OFS, 32'({pin, 6'h00}), 32'h0000_00C0, "pins");
        chk("slaveSel", 32'(pin[1]), 32'(serialSlaveSelect));
        chk("clkIn", 32'(dir[6] ? pin[0] : serialClockOut), 32'(serialClockIn));
        if (parportActive) chk("parportIn", 32'(pin), 32'(parportIn));
        if (membusActive && membusReadPhase) chk("membusIn", 32'(pin), 32'(membusIn));
      end
    end
    $display("test pin ownership done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rstPull2", 32'h0000_0000, 32'(pullupEn));
    $display("test second reset done");
    finish_test();
  end
endmodule // testbench
